// ==== pkg/lpm_pkg.sv ====
//
// Contract
// - Deep stop only on power-down with idle select 0, watchdog and voltage detector off.
// - Deep stop halts system, watchdog and time-base clocks and program execution.
// - Entering deep stop clears the watchdog counter and keeps it stopped.
// - Aux halt on power-down with idle select 0 and watchdog or detector enabled.
// - Aux halt stops system and time-base clocks; watchdog and detector run on aux.
// - Aux halt and both wait modes clear the watchdog, which resumes if enabled.
// - Idle select 1, keep-clock 0: system clock stops, time-base and aux run.
// - Idle select 1, keep-clock 1: all clocks run while execution halts.
// - Standby keeps memory, registers and port pin states unchanged.
// - Every power-down sets powered-down flag and clears watchdog-expiry flag.
// - Wake on enabled Port A falling edge, system interrupt or watchdog overflow.
// - Watchdog wake sets expiry flag and resets only program counter and stack pointer.
// - Powered-down flag clears on power-up or clear-watchdog instruction.
// - Per-pin Port A wake enables; wake resumes after the power-down instruction.
// - Disabled interrupt or full stack: resume after power-down, interrupt stays pending.
// - Enabled interrupt with free stack: normal interrupt response on wake.
// - Interrupt already requested before standby cannot wake the device.
// - One start-up counter; slow crystal period starts after fast oscillator period.
// - From deep stop into fast mode, run only after fast-ready flag is 1.
// - Aux halt wake with fast crystal and fast wake may run on slow oscillator.
// - Watchdog source clock runs exactly when the watchdog is enabled; reset loads its gate on regardless, until the first clock edge.
// - Fast wake with fast crystal: run on aux until 128 crystal ticks, then switch.
package lpm_pkg;

  localparam int PORTA_WIDTH = 8;
  localparam int IRQ_COUNT = 4;
  localparam int STAB_CNT_W = 8;

  // ---------------------------------------------------------------
  // Stabilisation lengths, in ticks of the oscillator that starts
  // ---------------------------------------------------------------
  localparam logic [STAB_CNT_W-1:0] FAST_XTAL_STAB_TICKS = 8'h80;
  localparam logic [STAB_CNT_W-1:0] INT_FAST_STAB_TICKS = 8'h10;
  localparam logic [STAB_CNT_W-1:0] SLOW_XTAL_STAB_TICKS = 8'h80;

  typedef enum logic [1:0] {
    DEEP_STOP_MODE = 2'h0,
    AUX_CLOCK_HALT_MODE = 2'h1,
    CORE_OFF_WAIT_MODE = 2'h2,
    FULL_CLOCK_WAIT_MODE = 2'h3
  } standby_mode_t;

  typedef enum logic [1:0] {
    SRC_INTERNAL_FAST_OSC = 2'h0,
    SRC_EXTERNAL_FAST_CRYSTAL = 2'h1,
    SRC_INTERNAL_SLOW_OSC = 2'h2,
    SRC_EXTERNAL_SLOW_CRYSTAL = 2'h3
  } clock_src_t;

  // Gray along run -> standby -> stabilise -> resume
  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_STANDBY = 2'h1,
    ST_STABILISE = 2'h3,
    ST_RESUME = 2'h2
  } seq_state_t;

  typedef enum logic [1:0] {
    WAKE_PORT = 2'h0,
    WAKE_IRQ = 2'h1,
    WAKE_WATCHDOG = 2'h2
  } wake_cause_t;

  typedef struct packed {
    logic sys;
    logic timebase;
    logic aux;
    logic watchdog;
  } clock_gate_t;

  localparam clock_gate_t GATES_RESET = 4'hf;

endpackage

// ==== hw/porta_fall_detect.sv ====
`timescale 1ns/1ps
`default_nettype none
module porta_fall_detect #(
  parameter int WIDTH = lpm_pkg::PORTA_WIDTH
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] wake_enable_in,
  output logic fall_out
);

  typedef struct packed {
    logic [WIDTH-1:0] prev;
    logic fall;
  } fall_state_t;

  fall_state_t r;
  fall_state_t n;
  logic [WIDTH-1:0] hit;

  // Pins idle high, so reset to ones avoids a false edge after reset
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      assign hit[i] = r.prev[i] & ~pin_in[i] & wake_enable_in[i];
    end
  endgenerate

  always_comb begin
    n = r;
    n.prev = pin_in;
    n.fall = |hit;
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '{prev: '1, fall: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign fall_out = r.fall;

  AST_MASKED_PIN: assert property (@(posedge clock_in) disable iff (rst_in)
    (wake_enable_in == '0) |=> !fall_out) else $error("masked pin raised wake");

endmodule
`default_nettype wire

// ==== hw/startup_stabilise_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
module startup_stabilise_counter #(
  parameter logic [lpm_pkg::STAB_CNT_W-1:0] SLOW_LEN = lpm_pkg::SLOW_XTAL_STAB_TICKS
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic need_fast_in,
  input wire logic need_slow_in,
  input wire logic [lpm_pkg::STAB_CNT_W-1:0] fast_len_in,
  input wire logic fast_tick_in,
  input wire logic slow_tick_in,
  output logic fast_done_out,
  output logic slow_done_out
);

  typedef struct packed {
    logic [lpm_pkg::STAB_CNT_W-1:0] cnt;
    logic [lpm_pkg::STAB_CNT_W-1:0] len;
    logic run_fast;
    logic run_slow;
    logic fast_done;
    logic slow_done;
  } stab_state_t;

  stab_state_t r;
  stab_state_t n;

  always_comb begin
    n = r;
    if (start_in) begin
      n.cnt = '0;
      n.len = fast_len_in;
      n.run_fast = need_fast_in;
      n.run_slow = need_slow_in;
      n.fast_done = ~need_fast_in;
      n.slow_done = ~need_slow_in;
    end else if (r.run_fast) begin
      if (fast_tick_in) begin
        if (r.cnt == r.len - 1'b1) begin
          n.cnt = '0;
          n.run_fast = 1'b0;
          n.fast_done = 1'b1;
        end else begin
          n.cnt = r.cnt + 1'b1;
        end
      end
    end else if (r.run_slow) begin
      if (slow_tick_in) begin
        if (r.cnt == SLOW_LEN - 1'b1) begin
          n.cnt = '0;
          n.run_slow = 1'b0;
          n.slow_done = 1'b1;
        end else begin
          n.cnt = r.cnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '{cnt: '0, len: '0, run_fast: 1'b0, run_slow: 1'b0, fast_done: 1'b1,
             slow_done: 1'b1};
    end else begin
      r <= n;
    end
  end

  assign fast_done_out = r.fast_done;
  assign slow_done_out = r.slow_done;

  AST_SLOW_AFTER_FAST: assert property (@(posedge clock_in) disable iff (rst_in)
    r.run_fast && !start_in |=> !$rose(r.slow_done)) else $error("slow done during fast");

endmodule
`default_nettype wire

// ==== hw/low_power_mode_controller.sv ====
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_controller #(
  parameter int PORTA_WIDTH = lpm_pkg::PORTA_WIDTH
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic halt_in,
  input wire logic clr_wdt_in,
  input wire logic idle_select_in,
  input wire logic idle_keep_clock_in,
  input wire logic watchdog_enable_in,
  input wire logic voltage_detector_enable_in,
  input wire logic fast_wake_enable_in,
  input wire lpm_pkg::clock_src_t sys_clock_src_in,
  input wire logic aux_from_slow_crystal_in,
  input wire logic fast_tick_in,
  input wire logic slow_tick_in,
  input wire logic watchdog_overflow_in,
  input wire logic [PORTA_WIDTH-1:0] porta_in,
  input wire logic [PORTA_WIDTH-1:0] porta_wake_enable_in,
  input wire logic [lpm_pkg::IRQ_COUNT-1:0] irq_request_in,
  input wire logic [lpm_pkg::IRQ_COUNT-1:0] irq_enable_in,
  input wire logic stack_full_in,
  output lpm_pkg::clock_gate_t clock_gate_out,
  output lpm_pkg::clock_src_t sys_clock_src_out,
  output lpm_pkg::standby_mode_t mode_out,
  output logic sys_on_aux_out,
  output logic cpu_halted_out,
  output logic io_hold_out,
  output logic watchdog_clear_out,
  output logic watchdog_run_out,
  output logic powered_down_flag_out,
  output logic watchdog_expiry_flag_out,
  output logic fast_osc_ready_out,
  output logic resume_next_out,
  output logic irq_service_out,
  output logic pc_sp_reset_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    lpm_pkg::seq_state_t state;
    lpm_pkg::standby_mode_t mode;
    lpm_pkg::clock_src_t src;
    lpm_pkg::wake_cause_t cause;
    lpm_pkg::clock_gate_t gates;
    logic [lpm_pkg::IRQ_COUNT-1:0] irq_arm;
    logic [lpm_pkg::IRQ_COUNT-1:0] irq_wake;
    logic need_fast;
    logic need_slow;
    logic start;
    logic on_aux;
    logic ready;
    logic halted;
    logic wdt_clear;
    logic wdt_run;
    logic pd;
    logic to;
    logic resume_next;
    logic irq_service;
    logic pc_sp_reset;
  } lpm_state_t;

  lpm_state_t r;
  lpm_state_t n;

  logic port_fall;
  logic fast_done;
  logic slow_done;
  logic src_is_fast;
  logic [lpm_pkg::STAB_CNT_W-1:0] fast_len;
  lpm_pkg::standby_mode_t pick_mode;
  logic wake_wdt;
  logic wake_irq;
  logic halt_now;

  porta_fall_detect #(.WIDTH(PORTA_WIDTH)) u_fall (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .pin_in(porta_in),
    .wake_enable_in(porta_wake_enable_in),
    .fall_out(port_fall)
  );

  startup_stabilise_counter u_stab (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .start_in(r.start),
    .need_fast_in(r.need_fast),
    .need_slow_in(r.need_slow),
    .fast_len_in(fast_len),
    .fast_tick_in(fast_tick_in),
    .slow_tick_in(slow_tick_in),
    .fast_done_out(fast_done),
    .slow_done_out(slow_done)
  );

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  assign src_is_fast = (r.src == lpm_pkg::SRC_INTERNAL_FAST_OSC) ||
                       (r.src == lpm_pkg::SRC_EXTERNAL_FAST_CRYSTAL);
  assign fast_len = (r.src == lpm_pkg::SRC_EXTERNAL_FAST_CRYSTAL) ?
                    lpm_pkg::FAST_XTAL_STAB_TICKS : lpm_pkg::INT_FAST_STAB_TICKS;
  assign halt_now = (r.state == lpm_pkg::ST_RUN) && halt_in;
  // A request already pending at entry is not armed, so only new requests wake
  assign wake_irq = |(irq_request_in & r.irq_arm);
  assign wake_wdt = watchdog_overflow_in && r.gates.watchdog;

  always_comb begin
    if (!idle_select_in) begin
      if (watchdog_enable_in || voltage_detector_enable_in) begin
        pick_mode = lpm_pkg::AUX_CLOCK_HALT_MODE;
      end else begin
        pick_mode = lpm_pkg::DEEP_STOP_MODE;
      end
    end else if (idle_keep_clock_in) begin
      pick_mode = lpm_pkg::FULL_CLOCK_WAIT_MODE;
    end else begin
      pick_mode = lpm_pkg::CORE_OFF_WAIT_MODE;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    n = r;
    n.start = 1'b0;
    n.wdt_clear = clr_wdt_in;
    n.resume_next = 1'b0;
    n.irq_service = 1'b0;
    n.pc_sp_reset = 1'b0;
    if (clr_wdt_in) begin
      n.pd = 1'b0;
    end
    if (halt_now) begin
      n.pd = 1'b1;
      n.to = 1'b0;
    end
    if (r.state == lpm_pkg::ST_STANDBY && wake_wdt) begin
      n.to = 1'b1;
    end
    // Done flags are stale in the cycle the counter loads, so wait out the start pulse
    if (r.state != lpm_pkg::ST_STANDBY && !r.start && (!r.need_slow || slow_done)) begin
      n.gates.aux = 1'b1;
    end
    case (r.state)
      lpm_pkg::ST_RUN: begin
        n.src = sys_clock_src_in;
        n.gates.watchdog = watchdog_enable_in;
        n.wdt_run = watchdog_enable_in;
        // Fast wake: leave the aux clock once the crystal has settled
        if (r.on_aux && fast_done) begin
          n.on_aux = 1'b0;
          n.ready = 1'b1;
        end
        if (halt_in) begin
          n.state = lpm_pkg::ST_STANDBY;
          n.halted = 1'b1;
          n.mode = pick_mode;
          n.irq_arm = ~irq_request_in;
          n.wdt_clear = 1'b1;
          n.on_aux = 1'b0;
          n.gates.sys = (pick_mode == lpm_pkg::FULL_CLOCK_WAIT_MODE);
          n.gates.timebase = (pick_mode == lpm_pkg::FULL_CLOCK_WAIT_MODE) ||
                             (pick_mode == lpm_pkg::CORE_OFF_WAIT_MODE);
          n.gates.aux = (pick_mode != lpm_pkg::DEEP_STOP_MODE);
          n.gates.watchdog = (pick_mode != lpm_pkg::DEEP_STOP_MODE) && watchdog_enable_in;
          n.wdt_run = (pick_mode != lpm_pkg::DEEP_STOP_MODE) && watchdog_enable_in;
          if (pick_mode != lpm_pkg::FULL_CLOCK_WAIT_MODE &&
              (sys_clock_src_in == lpm_pkg::SRC_INTERNAL_FAST_OSC ||
               sys_clock_src_in == lpm_pkg::SRC_EXTERNAL_FAST_CRYSTAL)) begin
            n.ready = 1'b0;
          end
        end
      end
      lpm_pkg::ST_STANDBY: begin
        if (wake_wdt || wake_irq || port_fall) begin
          n.irq_wake = irq_request_in & r.irq_arm;
          if (wake_wdt) begin
            n.cause = lpm_pkg::WAKE_WATCHDOG;
          end else if (wake_irq) begin
            n.cause = lpm_pkg::WAKE_IRQ;
          end else begin
            n.cause = lpm_pkg::WAKE_PORT;
          end
          if (r.mode == lpm_pkg::FULL_CLOCK_WAIT_MODE) begin
            n.state = lpm_pkg::ST_RESUME;
          end else if (fast_wake_enable_in && r.mode != lpm_pkg::DEEP_STOP_MODE &&
                       r.src == lpm_pkg::SRC_EXTERNAL_FAST_CRYSTAL) begin
            // Run on aux at once; the shared counter times the crystal meanwhile
            n.state = lpm_pkg::ST_RESUME;
            n.on_aux = 1'b1;
            n.start = 1'b1;
            n.need_fast = 1'b1;
            n.need_slow = 1'b0;
            n.gates.sys = 1'b1;
            n.gates.timebase = 1'b1;
          end else begin
            n.state = lpm_pkg::ST_STABILISE;
            n.start = 1'b1;
            n.need_fast = src_is_fast;
            n.need_slow = (r.mode == lpm_pkg::DEEP_STOP_MODE) && aux_from_slow_crystal_in;
          end
        end
      end
      lpm_pkg::ST_STABILISE: begin
        // Slow-source systems skip the fast period and wait for the slow crystal only when need_slow is set
        if (!r.start && (r.need_fast ? fast_done : (!r.need_slow || slow_done))) begin
          n.state = lpm_pkg::ST_RESUME;
          n.ready = r.ready | r.need_fast;
          n.gates.sys = 1'b1;
          n.gates.timebase = 1'b1;
        end
      end
      lpm_pkg::ST_RESUME: begin
        n.state = lpm_pkg::ST_RUN;
        n.halted = 1'b0;
        n.gates.sys = 1'b1;
        n.gates.timebase = 1'b1;
        n.gates.watchdog = watchdog_enable_in;
        n.wdt_run = watchdog_enable_in;
        case (r.cause)
          lpm_pkg::WAKE_WATCHDOG: n.pc_sp_reset = 1'b1;
          lpm_pkg::WAKE_IRQ: begin
            if (|(r.irq_wake & irq_enable_in) && !stack_full_in) begin
              n.irq_service = 1'b1;
            end else begin
              n.resume_next = 1'b1;
            end
          end
          default: n.resume_next = 1'b1;
        endcase
      end
      default: n.state = lpm_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '{state: lpm_pkg::ST_RUN, mode: lpm_pkg::DEEP_STOP_MODE,
             src: lpm_pkg::SRC_INTERNAL_FAST_OSC, cause: lpm_pkg::WAKE_PORT,
             gates: lpm_pkg::GATES_RESET, irq_arm: '0, irq_wake: '0, need_fast: 1'b0,
             need_slow: 1'b0, start: 1'b0, on_aux: 1'b0, ready: 1'b1, halted: 1'b0,
             wdt_clear: 1'b0, wdt_run: 1'b1, pd: 1'b0, to: 1'b0, resume_next: 1'b0,
             irq_service: 1'b0, pc_sp_reset: 1'b0};
    end else begin
      r <= n;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign clock_gate_out = r.gates;
  assign sys_clock_src_out = r.src;
  assign mode_out = r.mode;
  assign sys_on_aux_out = r.on_aux;
  assign cpu_halted_out = r.halted;
  assign io_hold_out = r.halted;
  assign watchdog_clear_out = r.wdt_clear;
  assign watchdog_run_out = r.wdt_run;
  assign powered_down_flag_out = r.pd;
  assign watchdog_expiry_flag_out = r.to;
  assign fast_osc_ready_out = r.ready;
  assign resume_next_out = r.resume_next;
  assign irq_service_out = r.irq_service;
  assign pc_sp_reset_out = r.pc_sp_reset;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  AST_DEEP_ENTRY: assert property (halt_now && !idle_select_in &&
    !watchdog_enable_in && !voltage_detector_enable_in |=>
    mode_out == lpm_pkg::DEEP_STOP_MODE && cpu_halted_out)
    else $error("deep stop not entered");
  AST_DEEP_GATES: assert property (r.state == lpm_pkg::ST_STANDBY &&
    mode_out == lpm_pkg::DEEP_STOP_MODE |-> !clock_gate_out.sys && !clock_gate_out.watchdog &&
    !clock_gate_out.timebase && cpu_halted_out) else $error("deep stop clocks running");
  AST_DEEP_WDT: assert property (halt_now && pick_mode == lpm_pkg::DEEP_STOP_MODE
    |=> watchdog_clear_out && !watchdog_run_out) else $error("watchdog not stopped");
  AST_AUX_ENTRY: assert property (halt_now && !idle_select_in && watchdog_enable_in
    |=> mode_out == lpm_pkg::AUX_CLOCK_HALT_MODE) else $error("aux halt not entered");
  AST_AUX_GATES: assert property (r.state == lpm_pkg::ST_STANDBY &&
    mode_out == lpm_pkg::AUX_CLOCK_HALT_MODE |-> !clock_gate_out.sys &&
    !clock_gate_out.timebase && clock_gate_out.aux) else $error("aux halt gates wrong");
  AST_WDT_RESUME: assert property (halt_now && pick_mode != lpm_pkg::DEEP_STOP_MODE &&
    watchdog_enable_in |=> watchdog_clear_out && watchdog_run_out) else $error("wdt not kept");
  AST_CORE_OFF: assert property (r.state == lpm_pkg::ST_STANDBY &&
    mode_out == lpm_pkg::CORE_OFF_WAIT_MODE |-> !clock_gate_out.sys &&
    clock_gate_out.timebase && clock_gate_out.aux) else $error("core-off gates wrong");
  AST_FULL_CLOCK: assert property (halt_now && idle_select_in && idle_keep_clock_in
    |=> clock_gate_out.sys && clock_gate_out.timebase && cpu_halted_out)
    else $error("full clock wait gates wrong");
  AST_FLAGS: assert property (halt_now |=> powered_down_flag_out &&
    !watchdog_expiry_flag_out) else $error("power-down flags wrong");
  AST_PD_CLEAR: assert property (clr_wdt_in && !halt_now |=> !powered_down_flag_out)
    else $error("powered-down flag not cleared");
  AST_WDT_WAKE: assert property (r.state == lpm_pkg::ST_STANDBY && wake_wdt
    |=> watchdog_expiry_flag_out && r.cause == lpm_pkg::WAKE_WATCHDOG)
    else $error("watchdog wake wrong");
  AST_WDT_PCSP: assert property (r.state == lpm_pkg::ST_RESUME &&
    r.cause == lpm_pkg::WAKE_WATCHDOG |=> pc_sp_reset_out && !irq_service_out &&
    !resume_next_out) else $error("watchdog wake did not reset pc and sp");
  AST_READY_FIRST: assert property ($rose(resume_next_out || irq_service_out) &&
    $past(mode_out) == lpm_pkg::DEEP_STOP_MODE && $past(r.need_fast) |-> fast_osc_ready_out)
    else $error("resumed before fast ready");
  AST_FAST_WAKE: assert property ($rose(sys_on_aux_out) |-> !fast_osc_ready_out &&
    clock_gate_out.sys) else $error("fast wake not on aux");

  COV_DEEP_WAKE: cover property (mode_out == lpm_pkg::DEEP_STOP_MODE &&
    r.state == lpm_pkg::ST_STABILISE ##[1:400] resume_next_out);
  COV_FAST_WAKE: cover property ($rose(sys_on_aux_out) ##[1:600] $fell(sys_on_aux_out));
  COV_IRQ_SERVICE: cover property (irq_service_out);
  COV_WDT_WAKE: cover property (pc_sp_reset_out);

endmodule
`default_nettype wire

// ==== dv/osc_tick_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Starting oscillators seen as tick pulses; larger divisors model a slow start
module osc_tick_model #(
  parameter int FAST_DIV = 2,
  parameter int SLOW_DIV = 4
) (
  input wire logic clock_in,
  input wire logic rst_in,
  output logic fast_tick_out,
  output logic slow_tick_out
);
  int cnt_r;
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= 0;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
  assign fast_tick_out = (cnt_r % FAST_DIV) == 0;
  assign slow_tick_out = (cnt_r % SLOW_DIV) == 0;
endmodule
`default_nettype wire

// ==== dv/low_power_mode_controller_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_controller_tb;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic halt, clr_wdt, idle_sel, keep_clk, wdt_en, lvd_en, fast_wake, ovf, stack_full;
  logic aux_slow;
  lpm_pkg::clock_src_t src, src_out;
  logic [7:0] pins, pin_en;
  logic [3:0] irq, irq_en;
  lpm_pkg::clock_gate_t gate;
  lpm_pkg::standby_mode_t mode;
  logic on_aux, halted, io_hold, wdt_clr, wdt_run, pd, to, ready, resume, isr, pcsp;
  logic fast_tick, slow_tick;
  int bad_count = 0;
  int tests_run = 0;

  always #25 clock_in = ~clock_in;

  osc_tick_model osc_tick_model_inst (.clock_in(clock_in), .rst_in(rst_in),
    .fast_tick_out(fast_tick), .slow_tick_out(slow_tick));

  low_power_mode_controller low_power_mode_controller_inst (
    .clock_in(clock_in), .rst_in(rst_in), .halt_in(halt), .clr_wdt_in(clr_wdt),
    .idle_select_in(idle_sel), .idle_keep_clock_in(keep_clk), .watchdog_enable_in(wdt_en),
    .voltage_detector_enable_in(lvd_en), .fast_wake_enable_in(fast_wake),
    .sys_clock_src_in(src), .aux_from_slow_crystal_in(aux_slow), .fast_tick_in(fast_tick),
    .slow_tick_in(slow_tick), .watchdog_overflow_in(ovf), .porta_in(pins),
    .porta_wake_enable_in(pin_en), .irq_request_in(irq), .irq_enable_in(irq_en),
    .stack_full_in(stack_full), .clock_gate_out(gate), .sys_clock_src_out(src_out),
    .mode_out(mode), .sys_on_aux_out(on_aux), .cpu_halted_out(halted), .io_hold_out(io_hold),
    .watchdog_clear_out(wdt_clr), .watchdog_run_out(wdt_run), .powered_down_flag_out(pd),
    .watchdog_expiry_flag_out(to), .fast_osc_ready_out(ready), .resume_next_out(resume),
    .irq_service_out(isr), .pc_sp_reset_out(pcsp));

  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (!ok) begin
      $display("unexpected at %0t ns: %s", $time, msg);
      bad_count++;
    end
  endtask

  task automatic close_out;
    if (bad_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Mode bits go up with the halt pulse, so the decision sees them at the taking edge
  task automatic enter(input logic i, k, w, l, input lpm_pkg::standby_mode_t m,
                       input logic [3:0] g);
    idle_sel = i;
    keep_clk = k;
    wdt_en = w;
    lvd_en = l;
    halt = 1'b1;
    @(negedge clock_in);
    halt = 1'b0;
    chk(mode === m && gate === g, "mode or gates");
    chk(halted === 1'b1 && io_hold === 1'b1, "halt or hold");
    chk(pd === 1'b1 && to === 1'b0, "entry flags");
    chk(wdt_clr === 1'b1 && wdt_run === w, "watchdog clear or run");
  endtask

  // Expected pulse order is {resume, irq service, pc/sp reset}
  task automatic wake(input logic [2:0] exp);
    int n;
    for (n = 0; n < 1000 && !(resume === 1'b1 || isr === 1'b1 || pcsp === 1'b1); n++) begin
      @(negedge clock_in);
    end
    if (n == 1000) begin
      chk(1'b0, "no wake");
      close_out();
    end
    chk({resume, isr, pcsp} === exp, "wake kind");
    chk(halted === 1'b0 && gate.sys === 1'b1, "clocks after wake");
  endtask

  task automatic pin_wake;
    pins[0] = 1'b0;
    wake(3'b100);
    pins[0] = 1'b1;
    @(negedge clock_in);
    chk(ready === 1'b1, "fast ready");
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic irq_case;
    irq = 4'h2;
    @(negedge clock_in);
    enter(1'b1, 1'b1, 1'b0, 1'b0, lpm_pkg::FULL_CLOCK_WAIT_MODE, 4'he);
    // Both pins fall with every wake enable off, then only pin 0 is re-enabled
    pins[1:0] = 2'b00;
    pin_en = 8'h00;
    repeat (40) @(negedge clock_in);
    chk(halted === 1'b1, "stale irq or disabled pin woke");
    pins[1:0] = 2'b11;
    pin_en = 8'h01;
    irq_en = 4'h4;
    irq = 4'h6;
    wake(3'b010);
    irq = 4'h0;
    @(negedge clock_in);
    enter(1'b1, 1'b1, 1'b0, 1'b0, lpm_pkg::FULL_CLOCK_WAIT_MODE, 4'he);
    stack_full = 1'b1;
    irq = 4'h4;
    wake(3'b100);
    stack_full = 1'b0;
    irq = 4'h0;
    @(negedge clock_in);
  endtask

  task automatic wdt_case;
    enter(1'b0, 1'b0, 1'b1, 1'b0, lpm_pkg::AUX_CLOCK_HALT_MODE, 4'h3);
    ovf = 1'b1;
    @(negedge clock_in);
    ovf = 1'b0;
    wake(3'b001);
    chk(to === 1'b1 && pd === 1'b1, "flags after watchdog wake");
    @(negedge clock_in);
    clr_wdt = 1'b1;
    @(negedge clock_in);
    clr_wdt = 1'b0;
    @(negedge clock_in);
    chk(pd === 1'b0, "clear-watchdog keeps pd");
  endtask

  task automatic fast_case;
    int n;
    src = lpm_pkg::SRC_EXTERNAL_FAST_CRYSTAL;
    fast_wake = 1'b1;
    enter(1'b0, 1'b0, 1'b1, 1'b0, lpm_pkg::AUX_CLOCK_HALT_MODE, 4'h3);
    pins[0] = 1'b0;
    wake(3'b100);
    pins[0] = 1'b1;
    chk(on_aux === 1'b1 && ready === 1'b0, "not on aux");
    for (n = 0; n < 1000 && ready !== 1'b1; n++) begin
      @(negedge clock_in);
    end
    if (n == 1000) begin
      chk(1'b0, "fast crystal never ready");
      close_out();
    end
    chk(ready === 1'b1 && on_aux === 1'b0, "no switch-over");
    chk(src_out === lpm_pkg::SRC_EXTERNAL_FAST_CRYSTAL, "source lost");
  endtask

  // Deep stop with a crystal aux clock: run after the fast period, aux waits for its own
  task automatic slow_case;
    int n;
    aux_slow = 1'b1;
    enter(1'b0, 1'b0, 1'b0, 1'b0, lpm_pkg::DEEP_STOP_MODE, 4'h0);
    pins[0] = 1'b0;
    wake(3'b100);
    pins[0] = 1'b1;
    chk(ready === 1'b1 && gate.aux === 1'b0, "aux before slow crystal");
    for (n = 0; n < 1000 && gate.aux !== 1'b1; n++) begin
      @(negedge clock_in);
    end
    if (n == 1000) begin
      chk(1'b0, "aux never reopened");
      close_out();
    end
    // Slow ticks come every fourth cycle from the model, so this is a loose floor
    chk(n > 3 * lpm_pkg::SLOW_XTAL_STAB_TICKS, "slow period too short");
    aux_slow = 1'b0;
  endtask

  initial begin
    {halt, clr_wdt, idle_sel, keep_clk, wdt_en, lvd_en, fast_wake, ovf, stack_full} = '0;
    aux_slow = 1'b0;
    src = lpm_pkg::SRC_INTERNAL_FAST_OSC;
    pins = 8'hff;
    pin_en = 8'h01;
    irq = 4'h0;
    irq_en = 4'h0;
    repeat (4) @(negedge clock_in);
    rst_in = 1'b0;
    chk(pd === 1'b0 && to === 1'b0 && gate === lpm_pkg::GATES_RESET, "reset");
    enter(1'b0, 1'b0, 1'b0, 1'b0, lpm_pkg::DEEP_STOP_MODE, 4'h0);
    pin_wake();
    enter(1'b0, 1'b0, 1'b1, 1'b0, lpm_pkg::AUX_CLOCK_HALT_MODE, 4'h3);
    pin_wake();
    enter(1'b0, 1'b0, 1'b0, 1'b1, lpm_pkg::AUX_CLOCK_HALT_MODE, 4'h2);
    pin_wake();
    enter(1'b1, 1'b0, 1'b1, 1'b0, lpm_pkg::CORE_OFF_WAIT_MODE, 4'h7);
    pin_wake();
    enter(1'b1, 1'b1, 1'b0, 1'b0, lpm_pkg::FULL_CLOCK_WAIT_MODE, 4'he);
    pin_wake();
    irq_case();
    wdt_case();
    slow_case();
    fast_case();
    close_out();
  end
endmodule
`default_nettype wire
